// ===== uvc_defs.svh
// Offsets, field positions, reset values and counts of the vendor block.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef UVC_DEFS_SVH
`define UVC_DEFS_SVH

`define UVC_FUNC_EHCI       3'h2
`define UVC_OFS_FRAME       8'h60
`define UVC_OFS_MISC        8'h68
`define UVC_REL_NUM         8'h20
`define UVC_FLA_RST         6'h20
`define UVC_FLA_LSB         8
`define UVC_FLA_MSB         13
`define UVC_PWM_RST         5'h0F
`define UVC_PWM_LSB         16
`define UVC_PWM_MSB         20
`define UVC_MISC_RST        16'h9000
`define UVC_MISC_WMASK      16'hFF7F
`define UVC_SOF_BASE        16'hE860
`define UVC_MRRS_64         12'h040
`define UVC_MRRS_128        12'h080
`define UVC_MRRS_NORMAL     12'h200
`define UVC_BIT_BASIC       0
`define UVC_BIT_B64         1
`define UVC_BIT_PREF        2
`define UVC_BIT_USER        4
`define UVC_USR_LSB         5
`define UVC_USR_MSB         6
`define UVC_PDW_LSB         8
`define UVC_PDW_MSB         14
`define UVC_USR_128         2'h0
`define UVC_PDW_RST         7'h10
`define UVC_PORTS_RST       4'h7
`define UVC_SOF_RST         16'hE880

`endif

// ===== uvc_pkg.sv
// Types shared by the vendor configuration block and its users.
// Assumes uvc_defs.svh is on the include path.
`default_nettype none
package uvc_pkg;
    // Configuration-space access from the function's config decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  func;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } uvc_cfg_req_t;

    // Settings that steer the host function
    typedef struct packed {
        logic        basicMode;
        logic        prefetchEn;
        logic [6:0]  prefetchDw;
        logic [11:0] mrrsBytes;
        logic        wakeMaskPresent;
        logic [3:0]  wakePortMask;
        logic [15:0] sofCycleTime;
    } uvc_ctrl_t;
endpackage : uvc_pkg
`default_nettype wire

// ===== uvc_vendor_cfg.sv
// Vendor configuration registers of the enhanced host function and the
// micro-frame SOF timer they steer.
// Assumes a config decoder presenting one-cycle access strobes on clk_sys
// and an autoload engine (SMBus or EEPROM) on the same clock.
`default_nettype none
`include "uvc_defs.svh"

// How it works
// - Registers exist only in enhanced function two
// - One field step adds one count to the cycle time
// - SOF cycle time is 59488 plus field
// - Frame length field resets to 32
// - Wake mask bit zero flags mask present
// - Wake mask bits one-four map ports
// - Basic mode allows one active controller
// - Bit one caps read requests at 64
// - Bit two enables prefetch, else none
// - Bit four selects user read request size
// - User size 00b means 128 bytes
// - Prefetch size in dwords, resets 16
// - Autoload replaces control field defaults
module uvc_vendor_cfg (
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire uvc_pkg::uvc_cfg_req_t cfgReq,
    output logic [31:0]                cfgRdData,
    output logic                       cfgRdValid,
    input  wire logic                  loadStb,
    input  wire logic [15:0]           loadMisc,
    output uvc_pkg::uvc_ctrl_t         ctrl,
    output logic                       sofStart
);
    import uvc_pkg::*;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [5:0]  flaReg,  flaNext;
    logic [4:0]  pwmReg,  pwmNext;
    logic [15:0] miscReg, miscNext;
    logic [31:0] rdReg,   rdNext;
    logic        rdvReg,  rdvNext;
    uvc_ctrl_t   ctrlReg, ctrlNext;
    logic        hitFunc;
    logic        hitFrame;
    logic        hitMisc;
    logic [31:0] wrMask;

    always_comb begin
        hitFunc  = (cfgReq.func == `UVC_FUNC_EHCI);
        hitFrame = hitFunc && (cfgReq.addr == `UVC_OFS_FRAME);
        hitMisc  = hitFunc && (cfgReq.addr == `UVC_OFS_MISC);
        wrMask   = {{8{cfgReq.be[3]}}, {8{cfgReq.be[2]}},
                    {8{cfgReq.be[1]}}, {8{cfgReq.be[0]}}};
        flaNext  = flaReg;
        pwmNext  = pwmReg;
        miscNext = miscReg;
        if (cfgReq.wr && hitFrame) begin
            flaNext = (cfgReq.wdata[`UVC_FLA_MSB:`UVC_FLA_LSB]
                       & wrMask[`UVC_FLA_MSB:`UVC_FLA_LSB])
                    | (flaReg & ~wrMask[`UVC_FLA_MSB:`UVC_FLA_LSB]);
            pwmNext = (cfgReq.wdata[`UVC_PWM_MSB:`UVC_PWM_LSB]
                       & wrMask[`UVC_PWM_MSB:`UVC_PWM_LSB])
                    | (pwmReg & ~wrMask[`UVC_PWM_MSB:`UVC_PWM_LSB]);
        end
        if (cfgReq.wr && hitMisc) begin
            miscNext = ((cfgReq.wdata[15:0] & wrMask[15:0])
                       | (miscReg & ~wrMask[15:0])) & `UVC_MISC_WMASK;
        end
        if (loadStb) begin
            miscNext = loadMisc & `UVC_MISC_WMASK;
        end
        rdNext = 32'h0000_0000;
        if (cfgReq.rd && hitFrame) begin
            rdNext = {11'h000, pwmReg, 2'h0, flaReg, `UVC_REL_NUM};
        end else if (cfgReq.rd && hitMisc) begin
            rdNext = {16'h0000, miscReg};
        end
        rdvNext = cfgReq.rd;
    end

    // ------------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------------
    always_comb begin
        ctrlNext.sofCycleTime    = `UVC_SOF_BASE + {10'h000, flaNext};
        ctrlNext.wakeMaskPresent = pwmNext[0];
        ctrlNext.wakePortMask    = pwmNext[4:1];
        ctrlNext.basicMode       = miscNext[`UVC_BIT_BASIC];
        ctrlNext.prefetchEn      = miscNext[`UVC_BIT_PREF];
        ctrlNext.prefetchDw      = miscNext[`UVC_PDW_MSB:`UVC_PDW_LSB];
        if (miscNext[`UVC_BIT_B64]) begin
            ctrlNext.mrrsBytes = `UVC_MRRS_64;
        end else if (miscNext[`UVC_BIT_USER]) begin
            // only 00b defined; reserved codes fall back to 128
            ctrlNext.mrrsBytes =
                (miscNext[`UVC_USR_MSB:`UVC_USR_LSB] == `UVC_USR_128)
                ? `UVC_MRRS_128 : `UVC_MRRS_128;
        end else begin
            ctrlNext.mrrsBytes = `UVC_MRRS_NORMAL;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flaReg  <= `UVC_FLA_RST;
            pwmReg  <= `UVC_PWM_RST;
            miscReg <= `UVC_MISC_RST;
            rdReg   <= 32'h0000_0000;
            rdvReg  <= 1'b0;
            ctrlReg <= '{basicMode: 1'b0, prefetchEn: 1'b0,
                         prefetchDw: `UVC_PDW_RST,
                         mrrsBytes: `UVC_MRRS_NORMAL,
                         wakeMaskPresent: 1'b1,
                         wakePortMask: `UVC_PORTS_RST,
                         sofCycleTime: `UVC_SOF_RST};
        end else begin
            flaReg  <= flaNext;
            pwmReg  <= pwmNext;
            miscReg <= miscNext;
            rdReg   <= rdNext;
            rdvReg  <= rdvNext;
            ctrlReg <= ctrlNext;
        end
    end

    assign cfgRdData  = rdReg;
    assign cfgRdValid = rdvReg;
    assign ctrl       = ctrlReg;

    // ------------------------------------------------------------------
    // SOF micro-frame timer
    // ------------------------------------------------------------------
    logic [15:0] sofCntReg, sofCntNext;
    logic        sofReg,    sofNext;

    always_comb begin
        // each step lengthens the frame by one count
        if (sofCntReg >= ctrlReg.sofCycleTime - 16'h0001) begin
            sofCntNext = 16'h0000;
            sofNext    = 1'b1;
        end else begin
            sofCntNext = sofCntReg + 16'h0001;
            sofNext    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sofCntReg <= 16'h0000;
            sofReg    <= 1'b0;
        end else begin
            sofCntReg <= sofCntNext;
            sofReg    <= sofNext;
        end
    end

    assign sofStart = sofReg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_OTHER_FUNC:
        assert property (cfgReq.wr && !hitFunc && !loadStb |=>
                         $stable(miscReg) && $stable(flaReg))
        else $error("write to another function changed a register");
    AST_FLA_STEP:
        assert property (cfgReq.wr && hitFrame && cfgReq.be[1] |=>
            ctrl.sofCycleTime == `UVC_SOF_BASE
                + {10'h000, $past(cfgReq.wdata[`UVC_FLA_MSB:`UVC_FLA_LSB])})
        else $error("frame length write not reflected in cycle time");
    AST_SOF_SUM:
        assert property (ctrl.sofCycleTime == `UVC_SOF_BASE
                         + {10'h000, flaReg})
        else $error("cycle time differs from base plus field");
    AST_SOF_GAP:
        assert property (sofStart |=> !sofStart [*8])
        else $error("SOF pulses too close together");
    AST_WAKE_MAP:
        assert property ({ctrl.wakePortMask, ctrl.wakeMaskPresent}
                         == pwmReg)
        else $error("wake mask outputs differ from register");
    AST_BASIC:
        assert property (loadStb |=>
                         ctrl.basicMode == $past(loadMisc[0]))
        else $error("basic mode not taken from autoload");
    AST_B64:
        assert property (miscReg[`UVC_BIT_B64] |->
                         ctrl.mrrsBytes == `UVC_MRRS_64)
        else $error("64-byte boundary not applied");
    AST_USER:
        assert property (!miscReg[`UVC_BIT_B64] && miscReg[`UVC_BIT_USER]
                         |-> ctrl.mrrsBytes == `UVC_MRRS_128)
        else $error("user read request size not applied");
    AST_PREF:
        assert property (ctrl.prefetchEn == miscReg[`UVC_BIT_PREF]
                         && ctrl.prefetchDw
                            == miscReg[`UVC_PDW_MSB:`UVC_PDW_LSB])
        else $error("prefetch outputs differ from register");
    AST_RSVD:
        assert property (cfgReq.rd && hitMisc |=>
                         cfgRdData[31:16] == 16'h0000
                         && cfgRdData[7] == 1'b0 && cfgRdValid)
        else $error("reserved misc bits read nonzero");

    COV_FRAME_WR: cover property (cfgReq.wr && hitFrame);
    COV_AUTOLOAD: cover property (loadStb ##1 ctrl.prefetchEn);
    COV_SOF:      cover property (sofStart);
    COV_USER:     cover property (ctrl.mrrsBytes == `UVC_MRRS_128);

endmodule : uvc_vendor_cfg
`default_nettype wire

// ===== uvc_vendor_cfg_test.sv
// Self-checking bench for the vendor configuration block of function two.
// Assumes uvc_defs.svh, uvc_pkg and uvc_vendor_cfg are compiled before it.
`default_nettype none
`include "uvc_defs.svh"

`define CHK(what, exp, act) \
    begin checks_done++; if ((act) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, act); end end

module uvc_vendor_cfg_test;
    timeunit 1ns;
    timeprecision 1ps;
    import uvc_pkg::*;

    logic          clk_sys;
    logic          arst_n;
    uvc_cfg_req_t  cfgReq;
    logic [31:0]   cfgRdData;
    logic          cfgRdValid;
    logic          loadStb;
    logic [15:0]   loadMisc;
    uvc_ctrl_t     ctrl;
    logic          sofStart;
    int            num_errors = 0;
    int            checks_done = 0;
    int            sofCnt;
    logic [31:0]   miscVal [5] = '{32'hFFFFFFFF, 32'h00000016, 32'h00000010,
                                   32'h00000070, 32'h00000001};
    logic [11:0]   mrrsExp [5] = '{12'h040, 12'h040, 12'h080, 12'h080,
                                   12'h200};

    uvc_vendor_cfg dut_u (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .cfgReq     (cfgReq),
        .cfgRdData  (cfgRdData),
        .cfgRdValid (cfgRdValid),
        .loadStb    (loadStb),
        .loadMisc   (loadMisc),
        .ctrl       (ctrl),
        .sofStart   (sofStart)
    );

    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Access tasks and verdict
    // ------------------------------------------------------------
    task automatic cfg_write(input logic [2:0] fn, input logic [7:0] adr,
                             input logic [3:0] ben, input logic [31:0] dat);
        cfgReq.func = fn;
        cfgReq.addr = adr;
        cfgReq.be = ben;
        cfgReq.wdata = dat;
        cfgReq.wr = 1'b1;
        @(posedge clk_sys);
        #2;
        cfgReq.wr = 1'b0;
        @(posedge clk_sys);
        #2;
    endtask : cfg_write

    task automatic cfg_read(input logic [2:0] fn, input logic [7:0] adr,
                            input logic [31:0] exp);
        cfgReq.func = fn;
        cfgReq.addr = adr;
        cfgReq.rd = 1'b1;
        @(posedge clk_sys);
        #2;
        cfgReq.rd = 1'b0;
        `CHK("cfgRdValid", 1'b1, cfgRdValid)
        `CHK("cfgRdData", exp, cfgRdData)
        @(posedge clk_sys);
        #2;
        `CHK("cfgRdValid low", 1'b0, cfgRdValid)
    endtask : cfg_read

    task automatic close_out();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        #2000000;
        num_errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        cfgReq = '0;
        loadStb = 1'b0;
        loadMisc = 16'h0000;
        arst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #2;
        arst_n = 1'b1;
        `CHK("sofCycleTime", 16'hE880, ctrl.sofCycleTime)
        `CHK("wakeMaskPresent", 1'b1, ctrl.wakeMaskPresent)
        `CHK("wakePortMask", 4'h7, ctrl.wakePortMask)
        `CHK("prefetchDw", 7'h10, ctrl.prefetchDw)
        `CHK("basicMode", 1'b0, ctrl.basicMode)
        // Default period: 59488 plus the reset field of 32
        sofCnt = 0;
        while (sofStart !== 1'b1 && sofCnt < 70000) begin
            @(posedge clk_sys);
            #2;
            sofCnt++;
        end
        `CHK("sof period", 59520, sofCnt)
        @(posedge clk_sys);
        #2;
        `CHK("sofStart pulse", 1'b0, sofStart)
        cfg_read(3'h2, 8'h60, 32'h000F2020);
        cfg_read(3'h2, 8'h68, 32'h00009000);
        cfg_write(3'h0, 8'h68, 4'hF, 32'hFFFFFFFF);
        cfg_read(3'h0, 8'h68, 32'h00000000);
        cfg_read(3'h2, 8'h68, 32'h00009000);
        cfg_read(3'h2, 8'h6C, 32'h00000000);
        cfg_write(3'h2, 8'h60, 4'hF, 32'hFFFFFFFF);
        cfg_read(3'h2, 8'h60, 32'h001F3F20);
        `CHK("sofCycleTime max", 16'hE89F, ctrl.sofCycleTime)
        `CHK("wakePortMask all", 4'hF, ctrl.wakePortMask)
        cfg_write(3'h2, 8'h60, 4'h2, 32'h00000500);
        `CHK("sofCycleTime five", 16'hE865, ctrl.sofCycleTime)
        cfg_read(3'h2, 8'h60, 32'h001F0520);
        for (int i = 0; i < 5; i++) begin
            cfg_write(3'h2, 8'h68, 4'hF, miscVal[i]);
            `CHK("mrrsBytes", mrrsExp[i], ctrl.mrrsBytes)
            `CHK("basicMode", miscVal[i][0], ctrl.basicMode)
            `CHK("prefetchEn", miscVal[i][2], ctrl.prefetchEn)
            `CHK("prefetchDw", miscVal[i][14:8], ctrl.prefetchDw)
            cfg_read(3'h2, 8'h68, miscVal[i] & 32'h0000FF7F);
        end
        // Autoload lands on the same edge as a config write
        cfgReq.func = 3'h2;
        cfgReq.addr = 8'h68;
        cfgReq.be = 4'hF;
        cfgReq.wdata = 32'h00000004;
        cfgReq.wr = 1'b1;
        loadStb = 1'b1;
        loadMisc = 16'h0015;
        @(posedge clk_sys);
        #2;
        cfgReq.wr = 1'b0;
        loadStb = 1'b0;
        `CHK("load basicMode", 1'b1, ctrl.basicMode)
        `CHK("load prefetchEn", 1'b1, ctrl.prefetchEn)
        `CHK("load mrrsBytes", 12'h080, ctrl.mrrsBytes)
        cfg_read(3'h2, 8'h68, 32'h00000015);
        // Mid-run reset brings back every default
        arst_n = 1'b0;
        @(posedge clk_sys);
        #2;
        arst_n = 1'b1;
        cfg_read(3'h2, 8'h60, 32'h000F2020);
        cfg_read(3'h2, 8'h68, 32'h00009000);
        `CHK("reset mrrsBytes", 12'h200, ctrl.mrrsBytes)
        close_out();
    end
endmodule : uvc_vendor_cfg_test
`default_nettype wire
